// ---- shared/lut_ctrl_pkg.sv ----
// Shared constants and types for the transfer-function control and notepad bank
package lut_ctrl_pkg;
    // Register offsets within the device map
    localparam logic [7:0] CHAN0_BASELINE_VALUE_HIGH_CTRL_OFS = 8'h68;
    localparam logic [7:0] CHAN0_BASELINE_VALUE_LOW_OFS       = 8'h69;
    localparam logic [7:0] CHAN1_BASELINE_VALUE_HIGH_CTRL_OFS = 8'h6A;
    localparam logic [7:0] CHAN1_BASELINE_VALUE_LOW_OFS       = 8'h6B;
    localparam logic [7:0] SCRATCH_FIRST_OFS        = 8'h6C;
    localparam logic [7:0] SCRATCH_LAST_OFS         = 8'h7F;
    // Bank geometry
    localparam int unsigned SCRATCH_COUNT = 20;
    localparam int unsigned BANK_COUNT    = 24;
    localparam int unsigned BASELINE_W    = 12;
    // Field positions in the upper control registers
    localparam int unsigned RESERVED_WR_BIT  = 7;
    localparam int unsigned RESERVED_RD_BIT  = 6;
    localparam int unsigned BYPASS_BIT       = 5;
    localparam int unsigned INCR_SIGN_BIT    = 4;
    localparam int unsigned BASELINE_VALUE_NIBBLE_MSB  = 3;
    // Reset values; control and notepad values held until the nonvolatile image has been loaded, read data until the first host read
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] LOW_RESET     = 8'h00;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET   = 8'h00;
    // Answer for an offset outside this bank
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // Per-channel control state
    typedef struct packed {
        logic       bypass;        // Send baseline straight to the output
        logic       incrementSign; // 1: table increments negative
        logic [3:0] baseHigh;      // Baseline bits 11:8
        logic [7:0] baseLow;       // Baseline bits 7:0
    } chan_ctrl_type;

    // One byte travelling to or from the nonvolatile engine
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } nv_byte_type;
endpackage

// ---- rtl/chan_output_select.sv ----
// Output source selection for one channel: baseline or arithmetic result
`timescale 1ns/1ps
module chan_output_select #(
    parameter int unsigned WIDTH = 12
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             bypass,
    input  wire logic [WIDTH-1:0] baselineValue,
    input  wire logic [WIDTH-1:0] aluResult,
    output logic      [WIDTH-1:0] outputValue
);
    logic [WIDTH-1:0] out_d;   // Next output value
    logic [WIDTH-1:0] out_q;   // Registered output value

    // Bypass picks the stored baseline, else the arithmetic unit
    always_comb begin
        if (bypass) begin
            out_d = baselineValue;
        end else begin
            out_d = aluResult;
        end
    end

    // Register so the top drives its output from a flop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign outputValue = out_q;
endmodule

// ---- rtl/lut_control_notepad_regs.sv ----
// Transfer-function control registers and notepad bank of the dual output device
//
// Contract
// RQ1: Channel 0 bypass set drives baseline out.
// RQ2: Channel 1 bypass set drives baseline out.
// RQ3: Channel 0 sign bit makes increments negative.
// RQ4: Channel 1 sign bit makes increments negative.
// RQ5: Channel 0 baseline is nibble plus low byte.
// RQ6: Channel 1 baseline is nibble plus low byte.
// RQ7: Host writes zero to bit seven.
// RQ8: Bit six always reads back zero.
// RQ9: Burn copies control registers to nonvolatile memory.
// RQ10: Power up reloads control and notepad bytes.
// RQ11: Twenty notepad bytes, no effect on operation.
// RQ12: Burn also copies notepad bytes out.
// RQ13: Host unlocks level two by password.
// RQ14: Host starts burn with command byte.
// RQ15: Baseline is the table point at 24C.
// RQ16: Writes ignored without level-two access.
`timescale 1ns/1ps
module lut_control_notepad_regs (
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    // Register port from the serial slave engine
    input  wire logic [7:0]                regAddr,
    input  wire logic                      regWrEn,
    input  wire logic [7:0]                regWrData,
    input  wire logic                      regRdEn,
    output logic      [7:0]                regRdData,
    // Access level from the password logic
    input  wire logic                      accessLevelTwo,
    // Power-up image bytes from the nonvolatile engine
    input  wire logic                      loadValid,
    input  wire lut_ctrl_pkg::nv_byte_type loadByte,
    // Burn request and outgoing bytes
    input  wire logic                      burnStart,
    output logic                           burnValid,
    output lut_ctrl_pkg::nv_byte_type      burnByte,
    output logic                           burnBusy,
    // Datapath side
    input  wire logic [11:0]               aluResult0,
    input  wire logic [11:0]               aluResult1,
    output logic      [11:0]               baselineValue0,
    output logic      [11:0]               baselineValue1,
    output logic                           incrementSign0,
    output logic                           incrementSign1,
    output logic      [11:0]               outputChan0,
    output logic      [11:0]               outputChan1
);
    typedef enum logic [1:0] {
        BURN_IDLE = 2'b01,
        BURN_WALK = 2'b10
    } burn_state_type;

    lut_ctrl_pkg::chan_ctrl_type chan_d [2];                     // Next channel controls
    lut_ctrl_pkg::chan_ctrl_type chan_q [2];                     // Channel controls
    logic [7:0]                  pad_d  [lut_ctrl_pkg::SCRATCH_COUNT]; // Next notepad
    logic [7:0]                  pad_q  [lut_ctrl_pkg::SCRATCH_COUNT]; // Notepad bytes
    logic [7:0]                  rdData_d;                       // Next read answer
    logic [7:0]                  rdData_q;                       // Read answer
    burn_state_type              state_d;                        // Next burn state
    burn_state_type              state_q;                        // Burn state
    logic [4:0]                  burnIdx_d;                      // Next burn index
    logic [4:0]                  burnIdx_q;                      // Byte being burnt
    logic                        burnValid_d;                    // Next burn strobe
    logic                        burnValid_q;                    // Burn strobe
    lut_ctrl_pkg::nv_byte_type   burnByte_d;                     // Next burn byte
    lut_ctrl_pkg::nv_byte_type   burnByte_q;                     // Burn byte
    logic [11:0]                 baseline_value_d [2];                     // Next baselines
    logic [11:0]                 baseline_value_q [2];                     // Baselines to datapath
    logic [1:0]                  sign_d;                         // Next increment signs
    logic [1:0]                  sign_q;                         // Increment signs

    // Read view of any bank byte; shared by host reads and burn walk
    function automatic logic [7:0] bankByte(
        input logic [7:0] addr,
        input lut_ctrl_pkg::chan_ctrl_type c0,
        input lut_ctrl_pkg::chan_ctrl_type c1,
        input logic [7:0] pad [lut_ctrl_pkg::SCRATCH_COUNT]
    );
        logic [7:0] v;
        v = lut_ctrl_pkg::UNMAPPED_DATA;
        case (addr)
            // Bits 7 and 6 always return zero
            lut_ctrl_pkg::CHAN0_BASELINE_VALUE_HIGH_CTRL_OFS: v = {2'b00, c0.bypass, c0.incrementSign,
                                                         c0.baseHigh}; // RQ8
            lut_ctrl_pkg::CHAN0_BASELINE_VALUE_LOW_OFS:       v = c0.baseLow;
            lut_ctrl_pkg::CHAN1_BASELINE_VALUE_HIGH_CTRL_OFS: v = {2'b00, c1.bypass, c1.incrementSign,
                                                         c1.baseHigh}; // RQ8
            lut_ctrl_pkg::CHAN1_BASELINE_VALUE_LOW_OFS:       v = c1.baseLow;
            default: begin
                if (addr >= lut_ctrl_pkg::SCRATCH_FIRST_OFS
                        && addr <= lut_ctrl_pkg::SCRATCH_LAST_OFS) begin
                    v = pad[5'(addr - lut_ctrl_pkg::SCRATCH_FIRST_OFS)];
                end
            end
        endcase
        return v;
    endfunction

    // Register updates: nonvolatile load first, then gated host writes
    always_comb begin
        chan_d = chan_q;
        pad_d  = pad_q;
        if (loadValid) begin
            // Image load bypasses the access gate and fills low bytes too
            case (loadByte.addr)
                lut_ctrl_pkg::CHAN0_BASELINE_VALUE_HIGH_CTRL_OFS: begin
                    chan_d[0].bypass        = loadByte.data[lut_ctrl_pkg::BYPASS_BIT]; // RQ10
                    chan_d[0].incrementSign = loadByte.data[lut_ctrl_pkg::INCR_SIGN_BIT];
                    chan_d[0].baseHigh      = loadByte.data[lut_ctrl_pkg::BASELINE_VALUE_NIBBLE_MSB:0];
                end
                lut_ctrl_pkg::CHAN0_BASELINE_VALUE_LOW_OFS:       chan_d[0].baseLow = loadByte.data; // RQ10
                lut_ctrl_pkg::CHAN1_BASELINE_VALUE_HIGH_CTRL_OFS: begin
                    chan_d[1].bypass        = loadByte.data[lut_ctrl_pkg::BYPASS_BIT]; // RQ10
                    chan_d[1].incrementSign = loadByte.data[lut_ctrl_pkg::INCR_SIGN_BIT];
                    chan_d[1].baseHigh      = loadByte.data[lut_ctrl_pkg::BASELINE_VALUE_NIBBLE_MSB:0];
                end
                lut_ctrl_pkg::CHAN1_BASELINE_VALUE_LOW_OFS:       chan_d[1].baseLow = loadByte.data; // RQ10
                default: begin
                    if (loadByte.addr >= lut_ctrl_pkg::SCRATCH_FIRST_OFS
                            && loadByte.addr <= lut_ctrl_pkg::SCRATCH_LAST_OFS) begin
                        pad_d[5'(loadByte.addr - lut_ctrl_pkg::SCRATCH_FIRST_OFS)]
                            = loadByte.data; // RQ10
                    end
                end
            endcase
        end else if (regWrEn && accessLevelTwo) begin // RQ16
            // Bit 7 is not stored, so a stray one from the host is harmless
            case (regAddr)
                lut_ctrl_pkg::CHAN0_BASELINE_VALUE_HIGH_CTRL_OFS: begin
                    chan_d[0].bypass        = regWrData[lut_ctrl_pkg::BYPASS_BIT];
                    chan_d[0].incrementSign = regWrData[lut_ctrl_pkg::INCR_SIGN_BIT];
                    chan_d[0].baseHigh      = regWrData[lut_ctrl_pkg::BASELINE_VALUE_NIBBLE_MSB:0];
                end
                lut_ctrl_pkg::CHAN1_BASELINE_VALUE_HIGH_CTRL_OFS: begin
                    chan_d[1].bypass        = regWrData[lut_ctrl_pkg::BYPASS_BIT];
                    chan_d[1].incrementSign = regWrData[lut_ctrl_pkg::INCR_SIGN_BIT];
                    chan_d[1].baseHigh      = regWrData[lut_ctrl_pkg::BASELINE_VALUE_NIBBLE_MSB:0];
                end
                default: begin
                    // Notepad is plain storage; only host reads and the burn walk read it
                    if (regAddr >= lut_ctrl_pkg::SCRATCH_FIRST_OFS
                            && regAddr <= lut_ctrl_pkg::SCRATCH_LAST_OFS) begin
                        pad_d[5'(regAddr - lut_ctrl_pkg::SCRATCH_FIRST_OFS)] = regWrData; // RQ11
                    end
                end
            endcase
        end
    end

    // Control and notepad storage
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < 2; c++) begin
                chan_q[c] <= {lut_ctrl_pkg::CTRL_RESET[5:0], lut_ctrl_pkg::LOW_RESET};
            end
            for (int i = 0; i < lut_ctrl_pkg::SCRATCH_COUNT; i++) begin
                pad_q[i] <= lut_ctrl_pkg::SCRATCH_RESET;
            end
        end else begin
            chan_q <= chan_d;
            pad_q  <= pad_d;
        end
    end

    // Datapath views, baseline valid at the 24C table point
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            baseline_value_d[c] = {chan_q[c].baseHigh, chan_q[c].baseLow}; // RQ5 RQ6 RQ15
            sign_d[c] = chan_q[c].incrementSign;                 // RQ3 RQ4
        end
    end

    // Registered baseline and sign outputs
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            baseline_value_q[0] <= '0;
            baseline_value_q[1] <= '0;
            sign_q    <= '0;
        end else begin
            baseline_value_q <= baseline_value_d;
            sign_q <= sign_d;
        end
    end

    // Host read answer, one cycle after the read enable
    always_comb begin
        rdData_d = rdData_q;
        if (regRdEn) begin
            rdData_d = bankByte(regAddr, chan_q[0], chan_q[1], pad_q);
        end
    end

    // Read data register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= lut_ctrl_pkg::RDATA_RESET;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // Burn walk: one byte per cycle over the whole bank
    always_comb begin
        state_d     = state_q;
        burnIdx_d   = burnIdx_q;
        burnValid_d = 1'b0;
        burnByte_d  = burnByte_q;
        case (state_q)
            BURN_IDLE: begin
                if (burnStart) begin
                    state_d   = BURN_WALK;
                    burnIdx_d = '0;
                end
            end
            BURN_WALK: begin
                // Walk covers control bytes then notepad bytes
                burnValid_d     = 1'b1; // RQ9 RQ12
                burnByte_d.addr = lut_ctrl_pkg::CHAN0_BASELINE_VALUE_HIGH_CTRL_OFS + 8'(burnIdx_q);
                burnByte_d.data = bankByte(burnByte_d.addr, chan_q[0], chan_q[1], pad_q);
                if (burnIdx_q == 5'(lut_ctrl_pkg::BANK_COUNT - 1)) begin
                    state_d = BURN_IDLE;
                end else begin
                    burnIdx_d = burnIdx_q + 5'h01;
                end
            end
            default: begin
                state_d = BURN_IDLE;
            end
        endcase
    end

    // Burn state registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= BURN_IDLE;
            burnIdx_q   <= '0;
            burnValid_q <= 1'b0;
            burnByte_q  <= '0;
        end else begin
            state_q     <= state_d;
            burnIdx_q   <= burnIdx_d;
            burnValid_q <= burnValid_d;
            burnByte_q  <= burnByte_d;
        end
    end

    // Output source selection, registered inside each instance
    chan_output_select #(.WIDTH(lut_ctrl_pkg::BASELINE_W)) selChan0 (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .bypass        (chan_q[0].bypass), // RQ1
        .baselineValue (baseline_value_d[0]),
        .aluResult     (aluResult0),
        .outputValue   (outputChan0)
    );

    chan_output_select #(.WIDTH(lut_ctrl_pkg::BASELINE_W)) selChan1 (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .bypass        (chan_q[1].bypass), // RQ2
        .baselineValue (baseline_value_d[1]),
        .aluResult     (aluResult1),
        .outputValue   (outputChan1)
    );

    assign regRdData      = rdData_q;
    assign burnValid      = burnValid_q;
    assign burnByte       = burnByte_q;
    assign burnBusy       = state_q[1]; // Walk bit of the one-hot state flop
    assign baselineValue0 = baseline_value_q[0];
    assign baselineValue1 = baseline_value_q[1];
    assign incrementSign0 = sign_q[0];
    assign incrementSign1 = sign_q[1];
endmodule

// ---- verification/regs_checker.sv ----
// Concurrent checks on the control and notepad register bank ports
`timescale 1ns/1ps
module regs_checker (
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    input  wire logic [7:0]                regAddr,
    input  wire logic                      regRdEn,
    input  wire logic [7:0]                regRdData,
    input  wire logic                      burnStart,
    input  wire logic                      burnValid,
    input  wire lut_ctrl_pkg::nv_byte_type burnByte,
    input  wire logic                      burnBusy,
    input  wire logic [11:0]               aluResult0,
    input  wire logic [11:0]               baselineValue0,
    input  wire logic [11:0]               outputChan0
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [5:0] busyCnt_q; // Busy cycles of the running walk
    logic [5:0] busyCnt_d; // Next count
    // Count restarts whenever the walk is idle, so a stuck busy shows up
    always_comb busyCnt_d = burnBusy ? busyCnt_q + 6'h01 : 6'h00;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) busyCnt_q <= 6'h00;
        else busyCnt_q <= busyCnt_d;
    end
    a_ctrl_bits_zero:
        assert property (regRdEn && (regAddr == 8'h68 || regAddr == 8'h6A)
            |=> regRdData[7:6] == 2'h0) else $error("upper control read shows bit 7 or 6");
    a_unmapped_read:
        assert property (regRdEn && regAddr < 8'h68 |=> regRdData == 8'h00)
            else $error("unmapped read not zero");
    a_rdata_holds:
        assert property (!regRdEn |=> $stable(regRdData)) else $error("read data moved");
    a_burn_begins:
        assert property (burnStart && !burnBusy |=> burnBusy ##1
            (burnValid && burnByte.addr == 8'h68)) else $error("burn walk did not begin");
    a_burn_ascends:
        assert property (burnValid && burnByte.addr != 8'h7F |=> burnValid &&
            burnByte.addr == $past(burnByte.addr) + 8'h01) else $error("burn order broken");
    a_burn_length:
        assert property ($fell(burnBusy) |-> busyCnt_q == 6'h18) else $error("busy length off");
    a_burn_last:
        assert property ($fell(burnBusy) |-> burnValid && burnByte.addr == 8'h7F)
            else $error("last burn byte missing");
    a_valid_in_walk:
        assert property (burnValid |-> burnBusy || $past(burnBusy))
            else $error("burn byte outside walk");
    a_out_source:
        assert property ($stable(baselineValue0) ##1 $stable(baselineValue0) |->
            outputChan0 == baselineValue0 || outputChan0 == $past(aluResult0))
            else $error("output source wrong");
    c_burn: cover property (burnStart && !burnBusy);
    c_burn_end: cover property ($fell(burnBusy));
    c_pad_read: cover property (regRdEn && regAddr == 8'h7F);
endmodule
bind lut_control_notepad_regs regs_checker i_regs_checker (.sys_clk(sys_clk),
    .reset_n(reset_n), .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData),
    .burnStart(burnStart), .burnValid(burnValid), .burnByte(burnByte), .burnBusy(burnBusy),
    .aluResult0(aluResult0), .baselineValue0(baselineValue0), .outputChan0(outputChan0));

// ---- verification/nv_image_model.sv ----
// Nonvolatile image model: power-up load stream and burn capture
`timescale 1ns/1ps
module nv_image_model (
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    output lut_ctrl_pkg::nv_byte_type      loadByte,
    output logic                           loadValid,
    output logic                           loadDone,
    input  wire logic                      burnValid,
    input  wire lut_ctrl_pkg::nv_byte_type burnByte
);
    logic [7:0] image [24];    // Stored bytes for offsets 0x68 to 0x7F
    int         burnCount = 0; // Bytes taken in by burns
    // Power-up stream, one byte a cycle, no gaps
    initial begin
        for (int i = 0; i < 24; i++) image[i] = 8'h80 + 8'(i);
        image[0] = 8'h3A;
        image[1] = 8'h5C;
        image[2] = 8'h05;
        image[3] = 8'hC3;
        loadValid = 1'b0;
        loadDone = 1'b0;
        loadByte = '{addr: 8'h00, data: 8'h00};
        wait (reset_n === 1'b1);
        @(posedge sys_clk);
        #2;
        for (int i = 0; i < 24; i++) begin
            loadValid = 1'b1;
            loadByte.addr = 8'h68 + 8'(i);
            loadByte.data = image[i];
            @(posedge sys_clk);
            #2;
        end
        // Stale data flipped so a late capture cannot pass by luck
        loadValid = 1'b0;
        loadByte.addr = 8'h00;
        loadByte.data = ~loadByte.data;
        loadDone = 1'b1;
    end
    // Capture of the burn stream into the image
    always @(posedge sys_clk) begin
        if (reset_n && burnValid) begin
            image[5'(burnByte.addr - 8'h68)] <= burnByte.data;
            burnCount <= burnCount + 1;
        end
    end
endmodule

// ---- verification/tb_lut_control_notepad_regs.sv ----
// Self-checking bench for the control and notepad register bank
`timescale 1ns/1ps
module tb_lut_control_notepad_regs;
    logic                      sys_clk, reset_n, regWrEn, regRdEn, accessLevelTwo, burnStart;
    logic                      loadValid, loadDone, burnValid, burnBusy, sign0, sign1;
    logic [7:0]                regAddr, regWrData, regRdData;
    logic [11:0]               alu0, alu1, base0, base1, out0, out1;
    lut_ctrl_pkg::nv_byte_type loadByte, burnByte;
    logic [7:0]                exp [24]; // Expected read view of the bank
    int                        err_total, n_checks, i;
    lut_control_notepad_regs i_lut_control_notepad_regs (.sys_clk(sys_clk), .reset_n(reset_n),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .accessLevelTwo(accessLevelTwo), .loadValid(loadValid),
        .loadByte(loadByte), .burnStart(burnStart), .burnValid(burnValid),
        .burnByte(burnByte), .burnBusy(burnBusy), .aluResult0(alu0), .aluResult1(alu1),
        .baselineValue0(base0), .baselineValue1(base1), .incrementSign0(sign0),
        .incrementSign1(sign1), .outputChan0(out0), .outputChan1(out1));
    nv_image_model i_nv_image_model (.sys_clk(sys_clk), .reset_n(reset_n), .loadByte(loadByte),
        .loadValid(loadValid), .loadDone(loadDone), .burnValid(burnValid), .burnByte(burnByte));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // Step past n edges, landing just after the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        cyc(1);
        regWrEn = 1'b0;
    endtask
    // Read answer is registered and held, so it is sampled after the next edge
    task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
        @(posedge sys_clk);
        #2;
        regAddr = a;
        regRdEn = 1'b1;
        cyc(1);
        regRdEn = 1'b0;
        check({4'h0, regRdData}, {4'h0, want});
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {regAddr, regWrData, regWrEn, regRdEn, accessLevelTwo, burnStart} = 20'h00000;
        alu0 = 12'h123;
        alu1 = 12'h456;
        err_total = 0;
        n_checks = 0;
        reset_n = 1'b0;
        for (i = 0; i < 24; i++) exp[i] = 8'h80 + 8'(i);
        exp[0] = 8'h3A;
        exp[1] = 8'h5C;
        exp[2] = 8'h05;
        exp[3] = 8'hC3;
        repeat (6) @(posedge sys_clk);
        #2 reset_n = 1'b1;
        for (i = 0; i < 100 && loadDone !== 1'b1; i++) cyc(1);
        if (loadDone !== 1'b1) err_total++;
        cyc(2);
        for (i = 0; i < 24; i++) rdchk(8'h68 + 8'(i), exp[i]);
        check(base0, 12'hA5C);
        check(out0, 12'hA5C);
        check({11'h000, sign0}, 12'h001);
        check(base1, 12'h5C3);
        check(out1, alu1);
        check({11'h000, sign1}, 12'h000);
        wr(8'h6C, 8'h77); // Still locked, must be dropped
        rdchk(8'h6C, exp[4]);
        accessLevelTwo = 1'b1;
        wr(8'h68, 8'h47);
        wr(8'h6A, 8'h3F);
        wr(8'h69, 8'hFF); // Low byte is load-only
        wr(8'h7F, 8'h11);
        wr(8'h6C, 8'hEE);
        exp[0] = 8'h07;
        exp[2] = 8'h3F;
        exp[4] = 8'hEE;
        exp[23] = 8'h11;
        cyc(2);
        rdchk(8'h68, 8'h07);
        rdchk(8'h69, 8'h5C);
        rdchk(8'h7F, 8'h11);
        rdchk(8'h6C, 8'hEE);
        rdchk(8'h10, 8'h00);
        check(out0, alu0);
        check({11'h000, sign0}, 12'h000);
        check(base0, 12'h75C);
        check(out1, 12'hFC3);
        check({11'h000, sign1}, 12'h001);
        check(base1, 12'hFC3);
        alu0 = 12'hABC;
        cyc(2);
        check(out0, 12'hABC);
        burnStart = 1'b1;
        cyc(1);
        burnStart = 1'b0;
        cyc(3);
        burnStart = 1'b1; // Second request mid-walk, to be ignored
        cyc(1);
        burnStart = 1'b0;
        for (i = 0; i < 100 && burnBusy !== 1'b0; i++) cyc(1);
        if (burnBusy !== 1'b0) err_total++;
        cyc(2);
        check(12'(i_nv_image_model.burnCount), 12'h018);
        for (i = 0; i < 24; i++) check({4'h0, i_nv_image_model.image[i]}, {4'h0, exp[i]});
        finish_test();
    end
endmodule
